// file: rtl/aabr_pkg.sv
// Operation
// (RULE_01) Stall upstream while downstream side in reset
// (RULE_02) Bursts become singles; transfer bit0, burst ignored
// (RULE_03) Downstream transfer type bit0 always low
// (RULE_04) Downstream burst type always SINGLE
// (RULE_05) Both resets assert together
// (RULE_06) Slave reset two cycles, synchronous release
// (RULE_07) Master reset two cycles, synchronous release
// (RULE_08) Activity outputs for AHB and APB ports
// (RULE_09) Master side clock always running
// (RULE_10) Initiator id carried to both ports
// (RULE_11) Request fields cross as held registers
// (RULE_12) Semaphore, read data, response cross back registered
// (RULE_13) Issue on AHB or APB per select
// (RULE_14) Toggle semaphore, two-stage sync, data held
// (RULE_15) Pending unlock issued before next transfer
`default_nettype none
package aabr_pkg;
  localparam logic [1:0] TRANS_IDLE   = 2'h0;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [2:0] BURST_SINGLE = 3'h0;
  localparam logic       SEMA_RST     = 1'h0;
  localparam int         SYNC_STAGES  = 2;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  prot;
    logic [1:0]  size;
    logic        write;
    logic        lock;
    logic        needUnlock;
    logic        selApb;
  } aabr_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        err;
  } aabr_resp_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_WDATA = 3'b001,
    S_HOLD  = 3'b010,
    S_WAIT  = 3'b011,
    S_ERR1  = 3'b100,
    S_ERR2  = 3'b101
  } aabr_sstate_t;

  typedef enum logic [2:0] {
    M_IDLE    = 3'b000,
    M_UNLOCK  = 3'b001,
    M_AADDR   = 3'b010,
    M_ADATA   = 3'b011,
    M_PSETUP  = 3'b100,
    M_PACCESS = 3'b101
  } aabr_mstate_t;
endpackage
`default_nettype wire

// file: rtl/aabr_bridge.sv
`timescale 1ns/100ps
`default_nettype none
module aabr_bridge #(
  parameter int IdW = 1
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              mstRst,
  input  wire logic              hSel,
  input  wire logic              hSelApb,
  input  wire logic              hReady,
  input  wire logic [31:0]       hAddr,
  input  wire logic [1:0]        upstreamTransferType,
  input  wire logic [2:0]        upstreamBurstType,
  input  wire logic [2:0]        hSize,
  input  wire logic [3:0]        hProt,
  input  wire logic              hWrite,
  input  wire logic              hMastLock,
  input  wire logic [IdW-1:0]    upstreamInitiatorId,
  input  wire logic [31:0]       hWdata,
  output logic                   hReadyOut,
  output logic                   hResp,
  output logic [31:0]            hRdata,
  output logic [31:0]            hAddrM,
  output logic [1:0]             downstreamTransferType,
  output logic [2:0]             downstreamBurstType,
  output logic [2:0]             hSizeM,
  output logic [3:0]             hProtM,
  output logic                   hWriteM,
  output logic                   hMastLockM,
  output logic [31:0]            hWdataM,
  output logic [IdW-1:0]         downstreamAhbInitiatorId,
  input  wire logic              hReadyM,
  input  wire logic              hRespM,
  input  wire logic [31:0]       hRdataM,
  output logic                   pSel,
  output logic                   pEnable,
  output logic [31:0]            pAddr,
  output logic                   pWrite,
  output logic [31:0]            pWdata,
  output logic [2:0]             pProt,
  output logic [3:0]             pStrb,
  output logic [IdW-1:0]         downstreamApbInitiatorId,
  input  wire logic              pReady,
  input  wire logic              pSlvErr,
  input  wire logic [31:0]       pRdata,
  output logic                   ahbPortActive,
  output logic                   apbPortActive
);
  aabr_pkg::aabr_sstate_t sState;
  aabr_pkg::aabr_mstate_t mState;
  aabr_pkg::aabr_req_t    sReq;
  aabr_pkg::aabr_resp_t   mResp;
  logic [31:0]            sWdata;
  logic [IdW-1:0]         sId;
  logic                   sTxSema;
  logic                   sLock;
  logic                   mTxSema;
  logic                   mReady;
  logic                   mLock;
  logic [aabr_pkg::SYNC_STAGES-1:0] mSemaInS;
  logic [aabr_pkg::SYNC_STAGES-1:0] mReadyInS;
  logic [aabr_pkg::SYNC_STAGES-1:0] sSemaInM;
  logic                   accept;
  logic                   sDone;
  logic                   mPending;
  logic                   mFinish;

  // Slave side: burst beats handled one at a time
  assign accept = hSel & hReady & upstreamTransferType[1] & hReadyOut; // RULE_02
  assign sDone  = (mSemaInS[aabr_pkg::SYNC_STAGES-1] == sTxSema);
  assign hReadyOut = (sState == aabr_pkg::S_IDLE) || (sState == aabr_pkg::S_ERR2);
  assign hResp     = (sState == aabr_pkg::S_ERR1) || (sState == aabr_pkg::S_ERR2);
  assign hRdata    = mResp.rdata; // RULE_12

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mSemaInS  <= '0;
      mReadyInS <= '0;
    end else begin
      mSemaInS  <= {mSemaInS[aabr_pkg::SYNC_STAGES-2:0], mTxSema}; // RULE_14
      mReadyInS <= {mReadyInS[aabr_pkg::SYNC_STAGES-2:0], mReady};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sState <= aabr_pkg::S_IDLE;
    end else begin
      case (sState)
        aabr_pkg::S_IDLE, aabr_pkg::S_ERR2: begin
          if (accept) begin
            sState <= hWrite ? aabr_pkg::S_WDATA : aabr_pkg::S_HOLD;
          end else begin
            sState <= aabr_pkg::S_IDLE;
          end
        end
        aabr_pkg::S_WDATA: sState <= aabr_pkg::S_HOLD;
        aabr_pkg::S_HOLD: begin
          if (mReadyInS[aabr_pkg::SYNC_STAGES-1]) begin // RULE_01
            sState <= aabr_pkg::S_WAIT;
          end
        end
        aabr_pkg::S_WAIT: begin
          if (sDone) begin
            sState <= mResp.err ? aabr_pkg::S_ERR1 : aabr_pkg::S_IDLE;
          end
        end
        aabr_pkg::S_ERR1: sState <= aabr_pkg::S_ERR2;
        default: sState <= aabr_pkg::S_IDLE;
      endcase
    end
  end

  // Request fields held stable until the far side answers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sReq <= '0;
      sId  <= '0;
      sLock <= 1'b0;
    end else if (accept) begin
      sReq.addr       <= hAddr; // RULE_11
      sReq.prot       <= hProt;
      sReq.size       <= hSize[1:0];
      sReq.write      <= hWrite;
      sReq.lock       <= hMastLock;
      sReq.needUnlock <= sLock & ~hMastLock; // RULE_15
      sReq.selApb     <= hSelApb;
      sId             <= upstreamInitiatorId; // RULE_10
      sLock           <= hMastLock;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sWdata <= '0;
    end else if (sState == aabr_pkg::S_WDATA) begin
      sWdata <= hWdata; // RULE_11
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sTxSema <= aabr_pkg::SEMA_RST;
    end else if (sState == aabr_pkg::S_HOLD && mReadyInS[aabr_pkg::SYNC_STAGES-1]) begin
      sTxSema <= ~sTxSema; // RULE_14
    end
  end

  // Master side
  assign mPending = (sSemaInM[aabr_pkg::SYNC_STAGES-1] != mTxSema);
  assign mFinish  = (mState == aabr_pkg::M_ADATA && hReadyM) ||
                    (mState == aabr_pkg::M_PACCESS && pReady);

  always_ff @(posedge clk_sys) begin
    if (mstRst) begin
      sSemaInM <= '0;
      mReady   <= 1'b0;
    end else begin
      sSemaInM <= {sSemaInM[aabr_pkg::SYNC_STAGES-2:0], sTxSema}; // RULE_14
      mReady   <= 1'b1; // RULE_01
    end
  end

  always_ff @(posedge clk_sys) begin
    if (mstRst) begin
      mState <= aabr_pkg::M_IDLE;
    end else begin
      case (mState)
        aabr_pkg::M_IDLE: begin
          if (mPending) begin
            if (sReq.needUnlock && mLock) begin
              mState <= aabr_pkg::M_UNLOCK; // RULE_15
            end else if (sReq.selApb) begin
              mState <= aabr_pkg::M_PSETUP; // RULE_13
            end else begin
              mState <= aabr_pkg::M_AADDR;
            end
          end
        end
        aabr_pkg::M_UNLOCK: mState <= sReq.selApb ? aabr_pkg::M_PSETUP : aabr_pkg::M_AADDR;
        aabr_pkg::M_AADDR:  mState <= aabr_pkg::M_ADATA;
        aabr_pkg::M_PSETUP: mState <= aabr_pkg::M_PACCESS;
        aabr_pkg::M_ADATA, aabr_pkg::M_PACCESS: begin
          if (mFinish) begin
            mState <= aabr_pkg::M_IDLE;
          end
        end
        default: mState <= aabr_pkg::M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (mstRst) begin
      mLock <= 1'b0;
    end else if (mState == aabr_pkg::M_IDLE && mPending) begin
      if (sReq.needUnlock && mLock) begin
        mLock <= 1'b0; // RULE_15
      end else if (!sReq.selApb) begin
        mLock <= sReq.lock;
      end
    end else if (mState == aabr_pkg::M_UNLOCK && !sReq.selApb) begin
      mLock <= sReq.lock;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (mstRst) begin
      mResp   <= '0;
      mTxSema <= aabr_pkg::SEMA_RST;
    end else if (mFinish) begin
      mResp.rdata <= (mState == aabr_pkg::M_PACCESS) ? pRdata : hRdataM; // RULE_12
      mResp.err   <= (mState == aabr_pkg::M_PACCESS) ? pSlvErr : hRespM;
      mTxSema     <= ~mTxSema;
    end
  end

  assign downstreamTransferType = (mState == aabr_pkg::M_AADDR) ? aabr_pkg::TRANS_NONSEQ
                                                                 : aabr_pkg::TRANS_IDLE; // RULE_03
  assign downstreamBurstType    = aabr_pkg::BURST_SINGLE; // RULE_04
  assign hAddrM                 = sReq.addr;
  assign hSizeM                 = {1'b0, sReq.size};
  assign hProtM                 = sReq.prot;
  assign hWriteM                = sReq.write;
  assign hMastLockM             = mLock;
  assign hWdataM                = sWdata;
  assign downstreamAhbInitiatorId = sId; // RULE_10
  assign downstreamApbInitiatorId = sId;

  assign pSel    = (mState == aabr_pkg::M_PSETUP) || (mState == aabr_pkg::M_PACCESS); // RULE_13
  assign pEnable = (mState == aabr_pkg::M_PACCESS);
  assign pAddr   = sReq.addr;
  assign pWrite  = sReq.write;
  assign pWdata  = sWdata;
  assign pProt   = {~sReq.prot[0], 1'b0, sReq.prot[1]};

  always_comb begin
    pStrb = 4'h0;
    if (sReq.write) begin
      case (sReq.size)
        2'h0:    pStrb = 4'(4'h1 << sReq.addr[1:0]);
        2'h1:    pStrb = sReq.addr[1] ? 4'hc : 4'h3;
        default: pStrb = 4'hf;
      endcase
    end
  end

  // Hold high across a locked sequence so gated clocks keep running
  assign ahbPortActive = (mState == aabr_pkg::M_UNLOCK) || (mState == aabr_pkg::M_AADDR) ||
                         (mState == aabr_pkg::M_ADATA) || mLock; // RULE_08
  assign apbPortActive = pSel; // RULE_08

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst || mstRst);

  sequence apbSetup;
    pSel && !pEnable;
  endsequence
  sequence apbAccess;
    pSel && pEnable;
  endsequence

  a_hold_in_reset: assert property (disable iff (srst) (sState == aabr_pkg::S_HOLD && !mReadyInS[1]) |=> // RULE_01
    (sState == aabr_pkg::S_HOLD && !hReadyOut && $stable(sTxSema)))
    else $error("transfer released while master side not ready");
  a_trans_bit0_low: assert property (!downstreamTransferType[0]) // RULE_03
    else $error("downstream transfer type bit 0 high");
  a_burst_single: assert property (downstreamBurstType == 3'h0) // RULE_04
    else $error("downstream burst not single");
  a_apb_active: assert property (pSel |-> apbPortActive && (ahbPortActive == mLock)) // RULE_08
    else $error("activity flags disagree with port");
  a_id_carried: assert property ((downstreamTransferType == aabr_pkg::TRANS_NONSEQ) |-> // RULE_10
    ##1 ($stable(downstreamAhbInitiatorId) && downstreamApbInitiatorId == downstreamAhbInitiatorId))
    else $error("initiator id not carried");
  a_req_stable: assert property ((sState == aabr_pkg::S_WAIT) |=> // RULE_11
    ($stable(sReq) && $stable(sWdata)) || $past(sDone))
    else $error("held request changed during crossing");
  a_resp_back: assert property (($changed(mTxSema) && sState == aabr_pkg::S_WAIT) |-> // RULE_12
    ##[2:3] (sState != aabr_pkg::S_WAIT))
    else $error("completion not seen by slave side");
  a_apb_select: assert property ((mState == aabr_pkg::M_IDLE && mPending && sReq.selApb && // RULE_13
    !(sReq.needUnlock && mLock)) |=> apbSetup ##1 apbAccess)
    else $error("apb transfer sequence wrong");
  a_sema_handoff: assert property (($changed(sTxSema) && mState == aabr_pkg::M_IDLE) |-> // RULE_14
    ##[2:3] (mState != aabr_pkg::M_IDLE))
    else $error("semaphore toggle not picked up");
  a_unlock_first: assert property ((mState == aabr_pkg::M_UNLOCK) |-> // RULE_15
    (!hMastLockM && downstreamTransferType == aabr_pkg::TRANS_IDLE) ##1 (mState != aabr_pkg::M_UNLOCK))
    else $error("unlock cycle malformed");
endmodule // aabr_bridge
`default_nettype wire

// file: dv/aabr_partner.sv
`timescale 1ns/100ps
`default_nettype none
module aabr_partner (
  input  wire logic        clk_sys,
  input  wire logic        mstRst,
  input  wire logic [1:0]  downstreamTransferType,
  input  wire logic [31:0] hAddrM,
  input  wire logic [31:0] hWdataM,
  input  wire logic        pSel,
  input  wire logic        pEnable,
  input  wire logic [31:0] pAddr,
  input  wire logic [31:0] pWdata,
  input  wire logic [1:0]  waits,
  output logic             hReadyM,
  output logic             hRespM,
  output logic [31:0]      hRdataM,
  output logic             pReady,
  output logic             pSlvErr,
  output logic [31:0]      pRdata,
  output logic [31:0]      seenAddr,
  output logic [31:0]      seenData
);
  logic        busy;
  logic [1:0]  cnt;
  logic [31:0] addr;
  // Read data valid (inverted address) only on the completing cycle, plain address otherwise
  assign hReadyM = !busy || cnt == 2'h0;
  assign hRdataM = (busy && cnt == 2'h0) ? ~addr : addr;
  // Error only on the completing cycle of a high-half address
  assign hRespM  = busy && cnt == 2'h0 && addr[31];
  assign pReady  = pSel && pEnable && cnt == 2'h0;
  assign pSlvErr = pReady && pAddr[31];
  assign pRdata  = pReady ? ~pAddr : pAddr;
  always_ff @(posedge clk_sys) begin
    if (mstRst) begin
      busy <= 1'h0;
      cnt  <= 2'h0;
    end else begin
      if (hReadyM) begin
        busy <= downstreamTransferType[1];
        addr <= hAddrM;
      end
      if ((hReadyM && downstreamTransferType[1]) || (pSel && !pEnable)) begin
        cnt <= waits;
      end else if (cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (busy && hReadyM) begin
      seenAddr <= addr;
      seenData <= hWdataM;
    end else if (pReady) begin
      seenAddr <= pAddr;
      seenData <= pWdata;
    end
  end
endmodule // aabr_partner
`default_nettype wire

// file: dv/aabr_bridge_test.sv
`timescale 1ns/100ps
`default_nettype none
module aabr_bridge_test;
  logic        clk_sys = 1'h0, srst = 1'h1, mstRst = 1'h1;
  logic        hSel = 1'h0, hSelApb = 1'h0, hWrite = 1'h0, hLock = 1'h0;
  logic [31:0] hAddr = 32'h0, hWdata = 32'h0;
  logic [1:0]  upstreamTransferType = 2'h0, upstreamInitiatorId = 2'h0, waits = 2'h0;
  logic [2:0]  upstreamBurstType = 3'h0;
  logic        hReady, hReadyOut, hResp, hReadyM, pSel, pEnable, pReady, pSlvErr;
  logic        hRespM, hWriteM, hMastLockM, pWrite;
  logic        ahbPortActive, apbPortActive, routeApb, routeWr, routeLock, prevLock;
  logic [31:0] hRdata, hAddrM, hWdataM, hRdataM, pAddr, pWdata, pRdata, seenAddr, seenData;
  logic [1:0]  downstreamTransferType, downstreamAhbInitiatorId, downstreamApbInitiatorId, routeId;
  logic [2:0]  downstreamBurstType, hSizeM, pProt;
  logic [3:0]  hProtM, pStrb;
  int          failCount = 0, checks = 0;
  assign hReady = hReadyOut;
  always #25 clk_sys = ~clk_sys;
  aabr_bridge #(.IdW(2)) dut (
    .clk_sys, .srst, .mstRst, .hSel, .hSelApb, .hReady, .hAddr, .upstreamTransferType,
    .upstreamBurstType, .hSize(3'h2), .hProt(4'h3), .hWrite, .hMastLock(hLock), .upstreamInitiatorId,
    .hWdata, .hReadyOut, .hResp, .hRdata, .hAddrM, .downstreamTransferType, .downstreamBurstType,
    .hSizeM, .hProtM, .hWriteM, .hMastLockM, .hWdataM, .downstreamAhbInitiatorId, .hReadyM,
    .hRespM, .hRdataM, .pSel, .pEnable, .pAddr, .pWrite, .pWdata, .pProt, .pStrb,
    .downstreamApbInitiatorId, .pReady, .pSlvErr, .pRdata, .ahbPortActive, .apbPortActive);
  aabr_partner far (
    .clk_sys, .mstRst, .downstreamTransferType, .hAddrM, .hWdataM, .pSel, .pEnable, .pAddr,
    .pWdata, .waits, .hReadyM, .hRespM, .hRdataM, .pReady, .pSlvErr, .pRdata, .seenAddr, .seenData);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_ready(output int cyc, output logic sawErr);
    cyc = 0;
    sawErr = 1'h0;
    while (!hReadyOut) begin
      sawErr = sawErr | hResp;
      @(negedge clk_sys);
      cyc++;
      if (cyc > 300) begin
        failCount++;
        final_report;
      end
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic wr, apb, input logic [1:0] tt,
                      input logic [2:0] bt, input logic expErr, output int cyc);
    logic e;
    @(negedge clk_sys);
    hSel = 1'h1;
    hAddr = a;
    hWrite = wr;
    hSelApb = apb;
    upstreamTransferType = tt;
    upstreamBurstType = bt;
    upstreamInitiatorId = a[3:2];
    wait_ready(cyc, e);
    @(negedge clk_sys);
    hSel = 1'h0;
    upstreamTransferType = 2'h0;
    hWdata = {a[15:0], a[31:16]};
    wait_ready(cyc, e);
    cmp(32'(hResp), 32'(expErr));
    cmp(32'(e), 32'(expErr));
    cmp(32'(routeApb), 32'(apb));
    cmp(32'(routeWr), 32'(wr));
    cmp(32'(routeId), 32'(a[3:2]));
    if (!apb) cmp(32'(routeLock), 32'(hLock));
    if (!wr && !expErr) cmp(hRdata, ~a);
    if (wr && !expErr) cmp(seenData, hWdata);
    if (!expErr) cmp(seenAddr, a);
  endtask
  always @(posedge clk_sys) begin
    prevLock <= hMastLockM;
    if (!srst && mstRst) cmp(32'(downstreamTransferType), 32'h0);
    if (!srst && !mstRst) begin
      cmp(32'(downstreamTransferType[0]), 32'h0);
      cmp(32'(downstreamBurstType), 32'h0);
      cmp(32'(apbPortActive), 32'(pSel));
      if (downstreamTransferType[1]) begin
        cmp(32'(ahbPortActive), 32'h1);
        cmp(32'({hSizeM, hProtM}), 32'h23);
        cmp(32'(prevLock & ~hMastLockM), 32'h0);
        routeApb <= 1'h0;
        routeId <= downstreamAhbInitiatorId;
        routeWr <= hWriteM;
        routeLock <= hMastLockM;
      end
      if (pSel) begin
        cmp(32'({pProt, pStrb}), pWrite ? 32'h1f : 32'h10);
        routeApb <= 1'h1;
        routeId <= downstreamApbInitiatorId;
        routeWr <= pWrite;
      end
    end
  end
  task automatic test_stall;
    int cyc;
    fork
      begin
        repeat (10) @(negedge clk_sys);
        mstRst = 1'h0;
      end
    join_none
    xfer(32'h0000_2004, 1'h0, 1'h0, 2'h2, 3'h0, 1'h0, cyc);
    cmp(32'(cyc > 12), 32'h1);
    $display("test_stall done");
  endtask
  task automatic test_ahb;
    int cyc;
    for (int i = 0; i < 8; i++) begin
      waits = i[1:0];
      xfer(32'h0000_1000 + 32'(i * 4), i[0], 1'h0, i[1] ? 2'h3 : 2'h2, i[2:0], 1'h0, cyc);
    end
    $display("test_ahb done");
  endtask
  task automatic test_apb;
    int cyc;
    for (int i = 0; i < 4; i++) begin
      waits = i[1:0];
      xfer({i[1], 31'h4000_0010} + 32'(i * 4), i[0], 1'h1, 2'h2, 3'h1, i[1], cyc);
    end
    $display("test_apb done");
  endtask
  task automatic test_lock;
    int cyc;
    waits = 2'h1;
    hLock = 1'h1;
    xfer(32'h0000_3008, 1'h0, 1'h0, 2'h2, 3'h0, 1'h0, cyc);
    hLock = 1'h0;
    xfer(32'h8000_300c, 1'h1, 1'h0, 2'h2, 3'h0, 1'h1, cyc);
    $display("test_lock done");
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    srst = 1'h0;
    test_stall;
    test_ahb;
    test_apb;
    test_lock;
    final_report;
  end
endmodule // aabr_bridge_test
`default_nettype wire
